// *** src/crpc_top.sv ***
// Core retention power control register and activity signalling
// Operation
// - Event-wait retention delay field, bits 9:7
// - Interrupt-wait retention delay field, bits 6:4
// - Nonzero codes select 2 to 512 ticks; code zero gives no readiness
// - No retention readiness before ticks elapse
// - Bit 0 requests power-down on interrupt wait
// - Power-down request resets to none
// - EL1/EL2 writes gated by auxiliary bit 7
// - Decode register at its system encoding
`timescale 1ns/1ps
module crpc_top (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// System register access
	input  wire logic        sr_req,
	input  wire logic        sr_write,
	input  wire logic [1:0]  sr_op0,
	input  wire logic [2:0]  sr_op1,
	input  wire logic [3:0]  sr_crn,
	input  wire logic [3:0]  sr_crm,
	input  wire logic [2:0]  sr_op2,
	input  wire logic [1:0]  sr_el,
	input  wire logic [31:0] sr_wdata,
	input  wire logic [63:0] aux_control_level2,
	input  wire logic [63:0] aux_control_level3,
	output logic             sr_ack,
	output logic             sr_trap,
	output logic [31:0]      sr_rdata,
	// Core state, same clock domain
	input  wire logic        wait_for_interrupt_state,
	input  wire logic        wait_for_event_state,
	// System counter tick, from another domain
	input  wire logic        sys_tick,
	// Power controller requests retention entry, from pins
	input  wire logic        ret_req,
	// P-Channel activity toward the power controller
	output logic [2:0]       power_activity_out,
	output logic             ret_accept
);
	typedef struct packed {
		logic [2:0]  evt_dly;
		logic [2:0]  irq_dly;
		logic        pdn;
		logic [2:0]  tick_sync;
		logic [1:0]  req_sync;
		logic [crpc_pkg::CNT_W-1:0] cnt;
		logic        ack;
		logic        trap;
		logic [31:0] rdata;
		logic [2:0]  act;
		logic        accept;
	} crpc_state_t;

	crpc_state_t st_ff;
	crpc_state_t nxt_st;

	// Decode and retention helpers, all but tick_edge also watched by the assertions
	logic                       hit;
	logic                       wr_ok;
	logic                       idle;
	logic [2:0]                 code;
	logic [crpc_pkg::CNT_W-1:0] need;
	logic                       ready;
	logic                       tick_edge;

	// Next-state logic for registers, counter and activity
	always_comb begin
		nxt_st = st_ff;
		hit = sr_op0 == crpc_pkg::ENC_OP0 && sr_op1 == crpc_pkg::ENC_OP1 &&
			sr_crn == crpc_pkg::ENC_CRN && sr_crm == crpc_pkg::ENC_CRM &&
			sr_op2 == crpc_pkg::ENC_OP2;
		// EL1 needs both auxiliary enables, EL2 only level 3; EL0 and EL3 always write
		wr_ok = aux_control_level3[crpc_pkg::AUX_TRAP_BIT] &&
			(sr_el == crpc_pkg::EL2 ||
			aux_control_level2[crpc_pkg::AUX_TRAP_BIT]);
		if (sr_el != crpc_pkg::EL1 && sr_el != crpc_pkg::EL2) begin
			wr_ok = 1'b1;
		end
		nxt_st.ack = sr_req;
		nxt_st.trap = 1'b0;
		if (sr_req && hit && sr_write) begin
			if (wr_ok) begin
				nxt_st.evt_dly = sr_wdata[crpc_pkg::EVT_HI:crpc_pkg::EVT_LO];
				nxt_st.irq_dly = sr_wdata[crpc_pkg::IRQ_HI:crpc_pkg::IRQ_LO];
				nxt_st.pdn = sr_wdata[crpc_pkg::PDN_BIT];
			end else begin
				nxt_st.trap = 1'b1;
			end
		end
		// Reserved bits read zero; unmatched encodings read zero too
		nxt_st.rdata = 32'h0000_0000;
		if (sr_req && hit && !sr_write) begin
			nxt_st.rdata[crpc_pkg::EVT_HI:crpc_pkg::EVT_LO] = st_ff.evt_dly;
			nxt_st.rdata[crpc_pkg::IRQ_HI:crpc_pkg::IRQ_LO] = st_ff.irq_dly;
			nxt_st.rdata[crpc_pkg::PDN_BIT] = st_ff.pdn;
		end
		// Synchronisers: stage 0 feeds only stage 1
		nxt_st.tick_sync = {st_ff.tick_sync[1:0], sys_tick};
		nxt_st.req_sync = {st_ff.req_sync[0], ret_req};
		tick_edge = st_ff.tick_sync[1] && !st_ff.tick_sync[2];
		// Interrupt wait takes priority over event wait for the delay
		idle = wait_for_interrupt_state || wait_for_event_state;
		code = wait_for_interrupt_state ? st_ff.irq_dly : st_ff.evt_dly;
		// Code zero needs no count; the ready term masks it off anyway
		unique case (code)
			3'h0: need = '0;
			3'h1: need = crpc_pkg::TICKS_C1;
			3'h2: need = crpc_pkg::TICKS_C2;
			3'h3: need = crpc_pkg::TICKS_C3;
			3'h4: need = crpc_pkg::TICKS_C4;
			3'h5: need = crpc_pkg::TICKS_C5;
			3'h6: need = crpc_pkg::TICKS_C6;
			3'h7: need = crpc_pkg::TICKS_C7;
		endcase
		if (!idle) begin
			nxt_st.cnt = '0;
		end else if (tick_edge && st_ff.cnt != need) begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end
		ready = idle && code != 3'h0 && st_ff.cnt == need;
		nxt_st.act = '0;
		nxt_st.act[crpc_pkg::ACT_RUN] = !idle;
		nxt_st.act[crpc_pkg::ACT_RET] = ready;
		nxt_st.act[crpc_pkg::ACT_OFF] =
			wait_for_interrupt_state && st_ff.pdn;
		nxt_st.accept = st_ff.req_sync[1] && ready;
	end

	// State register; clock enable freezes everything
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// Constants only; the fields take their reset defaults
			st_ff <= '0;
			st_ff.evt_dly <= crpc_pkg::DELAY_RST;
			st_ff.irq_dly <= crpc_pkg::DELAY_RST;
			st_ff.pdn <= crpc_pkg::PDN_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// Outputs come straight from the state register, no logic after it
	assign sr_ack = st_ff.ack;
	assign sr_trap = st_ff.trap;
	assign sr_rdata = st_ff.rdata;
	assign power_activity_out = st_ff.act;
	assign ret_accept = st_ff.accept;

	// Readiness shows only after the full count on a live code
	early_ret_a: assert property (
		@(posedge clk) disable iff (rst)
		st_ff.act[crpc_pkg::ACT_RET] |->
		$past(st_ff.cnt) == $past(need) && $past(code) != 3'h0)
		else $error("retention ready before ticks elapsed");
	// Accept follows a ready cycle, so an early request is refused
	accept_ret_a: assert property (
		@(posedge clk) disable iff (rst)
		st_ff.accept |-> $past(ready))
		else $error("retention accepted while not ready");
	// Accept also needs the synchronised request behind it
	accept_req_a: assert property (
		@(posedge clk) disable iff (rst)
		st_ff.accept |-> $past(st_ff.req_sync[1]))
		else $error("retention accepted without a request");
	// Leaving the wait restarts the count, so no credit carries over
	cnt_clear_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && !idle |=> st_ff.cnt == '0)
		else $error("idle counter not cleared");
	// Code zero keeps the retention circuit off
	ret_off_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && code == 3'h0 |=> !st_ff.act[crpc_pkg::ACT_RET])
		else $error("retention ready with code zero");
	// Both ends of the tick table
	tick_need_a: assert property (
		@(posedge clk) disable iff (rst)
		code == 3'h7 |-> need == 10'h200)
		else $error("wrong tick count for code 7");
	tick_short_a: assert property (
		@(posedge clk) disable iff (rst)
		code == 3'h1 |-> need == 10'h002)
		else $error("wrong tick count for code 1");
	// Power-down wish follows the interrupt wait
	pdn_act_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && wait_for_interrupt_state && st_ff.pdn |=>
		st_ff.act[crpc_pkg::ACT_OFF])
		else $error("power-down request not signalled");
	// Event wait alone never asks for power-down
	no_off_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && !wait_for_interrupt_state |=> !st_ff.act[crpc_pkg::ACT_OFF])
		else $error("power-down signalled outside interrupt wait");
	// Trapped write leaves every field alone
	trap_wr_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && sr_req && sr_write && hit && !wr_ok |=>
		st_ff.trap && $stable(st_ff.pdn) && $stable(st_ff.irq_dly) &&
		$stable(st_ff.evt_dly))
		else $error("trapped write changed register");
	// Permitted write lands in all three fields
	wr_take_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && sr_req && sr_write && hit && wr_ok |=>
		st_ff.evt_dly == $past(sr_wdata[9:7]) &&
		st_ff.irq_dly == $past(sr_wdata[6:4]) &&
		st_ff.pdn == $past(sr_wdata[0]) && !st_ff.trap)
		else $error("register write not taken");
	// A read hands back the stored fields
	rd_fields_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && sr_req && hit && !sr_write |=>
		st_ff.rdata[9:7] == $past(st_ff.evt_dly) &&
		st_ff.rdata[6:4] == $past(st_ff.irq_dly) &&
		st_ff.rdata[0] == $past(st_ff.pdn))
		else $error("read data differs from fields");
	// Writes return no data
	wr_zero_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && sr_req && sr_write |=> st_ff.rdata == 32'h0000_0000)
		else $error("write returned data");
	// Reserved bits always read zero
	rd_zero_a: assert property (
		@(posedge clk) disable iff (rst)
		st_ff.rdata[31:10] == 22'h00_0000 && st_ff.rdata[3:1] == 3'h0)
		else $error("reserved bits read nonzero");
	// Unmatched encodings answer with zero and never trap
	miss_zero_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && sr_req && !hit |=> st_ff.rdata == 32'h0000_0000 && !st_ff.trap)
		else $error("unmatched encoding answered");
	// Every request with clock enable high is acknowledged one cycle later
	ack_pulse_a: assert property (
		@(posedge clk) disable iff (rst)
		ce && sr_req |=> st_ff.ack)
		else $error("request not acknowledged");
endmodule : crpc_top

// *** src/crpc_pkg.sv ***
// Package of constants for the core retention power control block
package crpc_pkg;
	// System register encoding of the power control register
	localparam logic [1:0] ENC_OP0 = 2'h3;
	localparam logic [2:0] ENC_OP1 = 3'h0;
	localparam logic [3:0] ENC_CRN = 4'hf;
	localparam logic [3:0] ENC_CRM = 4'h2;
	localparam logic [2:0] ENC_OP2 = 3'h7;
	// Field positions
	localparam int EVT_HI = 9;
	localparam int EVT_LO = 7;
	localparam int IRQ_HI = 6;
	localparam int IRQ_LO = 4;
	localparam int PDN_BIT = 0;
	// Trap bit in the auxiliary control registers
	localparam int AUX_TRAP_BIT = 7;
	// Reset values
	localparam logic [2:0] DELAY_RST = 3'h0;
	localparam logic PDN_RST = 1'b0;
	// Exception levels
	localparam logic [1:0] EL1 = 2'h1;
	localparam logic [1:0] EL2 = 2'h2;
	// Tick counter width, enough for 512
	localparam int CNT_W = 10;
	// Required system counter ticks per nonzero retention code
	localparam logic [CNT_W-1:0] TICKS_C1 = 10'h002;
	localparam logic [CNT_W-1:0] TICKS_C2 = 10'h008;
	localparam logic [CNT_W-1:0] TICKS_C3 = 10'h020;
	localparam logic [CNT_W-1:0] TICKS_C4 = 10'h040;
	localparam logic [CNT_W-1:0] TICKS_C5 = 10'h080;
	localparam logic [CNT_W-1:0] TICKS_C6 = 10'h100;
	localparam logic [CNT_W-1:0] TICKS_C7 = 10'h200;
	// Power activity encoding
	localparam int ACT_W = 3;
	localparam int ACT_RUN = 0;
	localparam int ACT_RET = 1;
	localparam int ACT_OFF = 2;
endpackage : crpc_pkg

// *** testbench/crpc_pwr_model.sv ***
// Power controller model facing the activity lines
`timescale 1ns/1ps
module crpc_pwr_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Activity in, retention request out
	input  wire logic [2:0] act,
	input  wire logic       eager,
	output logic            ret_req
);
	// Asks once ready shows; eager asks early to probe refusal
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ret_req <= 1'b0;
		end else begin
			ret_req <= eager | act[1];
		end
	end
endmodule : crpc_pwr_model

// *** testbench/tb_crpc_top.sv ***
// Self-checking bench for the retention power control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_crpc_top;
	logic        clk, rst, sr_req, sr_write, sr_ack, sr_trap;
	logic        wi, we, sys_tick, eager, ret_req, ret_accept, ce;
	logic [1:0]  el;
	logic [2:0]  act;
	logic [3:0]  sr_crm;
	logic [31:0] sr_wdata, rd;
	logic [63:0] a2, a3;
	int          errors, checks, cyc;
	int          need [7] = '{2, 8, 32, 64, 128, 256, 512};

	crpc_top crpc_top_i (.clk, .rst, .ce, .sr_req, .sr_write,
		.sr_op0(crpc_pkg::ENC_OP0), .sr_op1(crpc_pkg::ENC_OP1),
		.sr_crn(crpc_pkg::ENC_CRN), .sr_crm, .sr_op2(crpc_pkg::ENC_OP2),
		.sr_el(el), .sr_wdata, .aux_control_level2(a2),
		.aux_control_level3(a3), .sr_ack, .sr_trap, .sr_rdata(rd),
		.wait_for_interrupt_state(wi), .wait_for_event_state(we),
		.sys_tick, .ret_req, .power_activity_out(act), .ret_accept);
	crpc_pwr_model crpc_pwr_model_i (.clk, .rst, .act, .eager, .ret_req);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard: the tick sweep needs about 8100 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	// One access; answer stands in the cycle after the request
	task automatic acc(input logic w, input logic [1:0] e,
			input logic [3:0] m, input logic [31:0] d);
		@(negedge clk);
		sr_req = 1'b1;
		{sr_write, el, sr_crm, sr_wdata} = {w, e, m, d};
		@(negedge clk);
		sr_req = 1'b0;
		`CHK("ack", 1'b1, sr_ack)
	endtask : acc

	// Slow ticks so the synchroniser sees every edge
	task automatic ticks(input int n);
		repeat (n) begin
			sys_tick = 1'b1;
			repeat (4) @(negedge clk);
			sys_tick = 1'b0;
			repeat (4) @(negedge clk);
		end
	endtask : ticks

	initial begin
		{sr_req, sr_write, wi, we, sys_tick, eager, el, sr_crm} = '0;
		{sr_wdata, a2, a3} = '0;
		ce = 1'b1;
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		acc(1'b0, 2'h1, 4'h2, '0);
		`CHK("reset", 32'h0000_0000, rd)
		`CHK("run", 1'b1, act[0])
		acc(1'b1, 2'h3, 4'h2, 32'hffff_ffff);
		acc(1'b0, 2'h0, 4'h2, '0);
		`CHK("fields", 32'h0000_03f1, rd)
		acc(1'b0, 2'h3, 4'h3, '0);
		`CHK("miss", 32'h0000_0000, rd)
		wi = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("pdn", 2'b10, {act[2], act[0]})
		wi = 1'b0;
		$display("test regs done");
		// Level 1 needs both trap bits, level 2 only the upper one
		a3[7] = 1'b1;
		acc(1'b1, 2'h1, 4'h2, '0);
		`CHK("trap", 1'b1, sr_trap)
		acc(1'b0, 2'h3, 4'h2, '0);
		`CHK("kept", 32'h0000_03f1, rd)
		acc(1'b1, 2'h2, 4'h2, '0);
		`CHK("no trap", 1'b0, sr_trap)
		a3[7] = 1'b0;
		acc(1'b1, 2'h2, 4'h2, 32'h0000_0001);
		`CHK("el2 trap", 1'b1, sr_trap)
		// Clock enable low: the request must leave no trace
		@(negedge clk);
		{ce, sr_req, sr_write, el} = {1'b0, 1'b1, 1'b1, 2'h3};
		sr_wdata = 32'h0000_03f1;
		@(negedge clk);
		`CHK("frozen ack", 1'b0, sr_ack)
		{ce, sr_req} = 2'b10;
		acc(1'b0, 2'h3, 4'h2, '0);
		`CHK("frozen", 32'h0000_0000, rd)
		$display("test trap done");
		// Every nonzero code; odd ones idle on event wait, even on interrupt wait
		eager = 1'b1;
		for (int c = 1; c < 8; c++) begin
			acc(1'b1, 2'h3, 4'h2, 32'(c * 144));
			{we, wi} = c[0] ? 2'b10 : 2'b01;
			ticks(need[c-1] - 1);
			`CHK("early", 2'b00, {act[1], ret_accept})
			ticks(1);
			`CHK("ready", 3'b011, {act[2:1], ret_accept})
			{we, wi} = 2'b00;
		end
		$display("test retention done");
		end_of_test();
	end
endmodule : tb_crpc_top
